// *** common/mram_spi_pkg.sv ***
/*
  Shared constants and types for the serial memory command front end:
  opcodes, status bit positions, address sizing and the write record.
  Assumes a single 25 MHz system clock samples every pin of the serial link.
*/
package mram_spi_pkg;

  // Opcodes
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_DISARM = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_ARM = 8'h06;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;

  // Status register layout
  localparam int STATUS_LOCK_POS = 7;
  localparam int GUARD_HI_POS = 3;
  localparam int GUARD_LO_POS = 2;
  localparam int ARM_POS = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Addressing: 24 bits arrive, only the low ones are decoded
  localparam int MEM_ADDR_BITS = 19;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Write buffer depth
  localparam int WR_FIFO_DEPTH = 32;

  typedef struct packed {
    logic [MEM_ADDR_BITS-1:0] addr;
    logic [7:0] data;
  } mem_write_t;

endpackage

// *** design/mram_spi_front.sv ***
/*
  Serial command front end of a byte-wide non-volatile memory, plus the
  buffer that carries accepted write bytes to the array.
  Assumes the array sits outside: writes drain from the buffer, reads have a
  fixed one-cycle latency. Pins are asynchronous to clock and are synchronised.
*/
`timescale 1ns/10ps

module mram_write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << PW) != DEPTH)
      $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  // Extra pointer bit tells full from empty
  assign in_ready = (wr_q[PW] == rd_q[PW]) || (wr_q[PW-1:0] != rd_q[PW-1:0]);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem_q[wr_q[PW-1:0]] <= in_data;
  end
endmodule

module mram_spi_front
  import mram_spi_pkg::*;
#(
  parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  // Array read port, data valid one cycle after the enable
  output logic mem_rd_en,
  output logic [MEM_ADDR_BITS-1:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  // Array write port
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output mem_write_t mem_wr,
  // Status
  output logic [7:0] status,
  output logic mode3,
  output logic sleeping,
  output logic hw_protect,
  output logic wr_overrun
);
  typedef enum {S_IDLE, S_OPCODE, S_ADDR, S_RDATA, S_WDATA, S_SRREAD, S_SRWRITE, S_IGNORE} state_t;

  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("write buffer too shallow");
  end

  // Upper region covered by the guard pair
  function automatic logic guarded(input logic [1:0] g, input logic [MEM_ADDR_BITS-1:0] a);
    logic r;
    case (g)
      2'b01: r = &a[MEM_ADDR_BITS-1 -: 2];
      2'b10: r = a[MEM_ADDR_BITS-1];
      2'b11: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Two-stage synchronisers; sck keeps a third stage for edge finding
  logic cs_s1, cs_s2, sck_s1, sck_s2, sck_s3, si_s1, si_s2;
  logic hold_s1, hold_s2, wp_s1, wp_s2;

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      {cs_s1, cs_s2, hold_s1, hold_s2, wp_s1, wp_s2} <= 6'h3F;
      {sck_s1, sck_s2, sck_s3, si_s1, si_s2} <= 5'h00;
    end
    else
    begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1 <= si;
      si_s2 <= si_s1;
      hold_s1 <= hold_n;
      hold_s2 <= hold_s1;
      wp_s1 <= wp_n;
      wp_s2 <= wp_s1;
    end
  end

  state_t state_q, state_d;
  logic cs_active_q, cs_active_d;
  logic [2:0] bit_q, bit_d;
  logic [6:0] shift_q, shift_d;
  logic [1:0] abyte_q, abyte_d;
  logic is_read_q, is_read_d;
  logic [MEM_ADDR_BITS-1:0] addr_q, addr_d, addr_new;
  logic [7:0] tx_q, tx_d, status_q, status_d, byte_in;
  logic so_q, so_d, so_oe_q, so_oe_d, mode3_q, mode3_d, sleep_q, sleep_d;
  logic rd_en_q, rd_en_d, hw_q, hw_d, ovr_q, ovr_d;
  logic rd_dv_q, rd_dv_d;
  logic [MEM_ADDR_BITS-1:0] rd_addr_q, rd_addr_d;
  logic cs_fall, cs_rise, rise_e, fall_e, byte_done;
  logic push, push_ready;
  mem_write_t push_rec;

  // Hold freezes select and clock edges alike
  assign cs_fall = hold_s2 && !cs_s2 && !cs_active_q;
  assign cs_rise = hold_s2 && cs_s2 && cs_active_q;
  assign rise_e = hold_s2 && cs_active_q && sck_s2 && !sck_s3;
  assign fall_e = hold_s2 && cs_active_q && !sck_s2 && sck_s3;
  assign byte_in = {shift_q, si_s2};
  assign byte_done = rise_e && bit_q == BIT_LAST;
  assign addr_new = MEM_ADDR_BITS'({addr_q, byte_in});

  always_comb
  begin
    state_d = state_q;
    cs_active_d = cs_active_q;
    bit_d = bit_q;
    shift_d = shift_q;
    abyte_d = abyte_q;
    is_read_d = is_read_q;
    addr_d = addr_q;
    tx_d = tx_q;
    so_d = so_q;
    status_d = status_q;
    mode3_d = mode3_q;
    sleep_d = sleep_q;
    rd_en_d = 1'b0;
    rd_dv_d = rd_en_q;
    rd_addr_d = rd_addr_q;
    ovr_d = ovr_q;
    push = 1'b0;
    push_rec = '{addr: addr_q, data: byte_in};
    // Array answers one cycle after the strobe, so load from the delayed copy
    if (rd_dv_q)
      tx_d = mem_rd_data;
    if (rise_e)
    begin
      bit_d = bit_q + 3'h1;
      shift_d = byte_in[6:0];
    end
    if ((state_q == S_RDATA || state_q == S_SRREAD) && fall_e)
    begin
      so_d = tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
    if (byte_done)
    begin
      case (state_q)
        S_OPCODE:
        begin
          state_d = S_IGNORE;
          if (sleep_q)
            sleep_d = byte_in != OP_WAKE;
          else
          begin
            case (byte_in)
              OP_ARM: status_d[ARM_POS] = 1'b1;
              OP_DISARM: status_d[ARM_POS] = 1'b0;
              OP_STATUS_READ:
              begin
                tx_d = status_q;
                state_d = S_SRREAD;
              end
              OP_STATUS_WRITE: state_d = S_SRWRITE;
              OP_MEM_READ, OP_MEM_WRITE:
              begin
                is_read_d = byte_in == OP_MEM_READ;
                abyte_d = 2'h0;
                state_d = S_ADDR;
              end
              OP_SLEEP: sleep_d = 1'b1;
              default: state_d = S_IGNORE;
            endcase
          end
        end
        S_ADDR:
        begin
          addr_d = addr_new;
          abyte_d = abyte_q + 2'h1;
          if (abyte_q == ADDR_LAST_BYTE)
          begin
            if (is_read_q)
            begin
              rd_en_d = 1'b1;
              rd_addr_d = addr_new;
              addr_d = addr_new + 1'b1;
              state_d = S_RDATA;
            end
            else
              state_d = S_WDATA;
          end
        end
        S_RDATA:
        begin
          rd_en_d = 1'b1;
          rd_addr_d = addr_q;
          addr_d = addr_q + 1'b1;
        end
        S_WDATA:
        begin
          // Protected or disarmed bytes vanish; the address still moves on
          if (status_q[ARM_POS] && !guarded(status_q[GUARD_HI_POS:GUARD_LO_POS], addr_q))
          begin
            push = push_ready;
            ovr_d = ovr_q || !push_ready;
          end
          addr_d = addr_q + 1'b1;
        end
        S_SRREAD: tx_d = status_q;
        S_SRWRITE:
        begin
          if (status_q[ARM_POS] && (!status_q[STATUS_LOCK_POS] || wp_s2))
            status_d = {byte_in[7:2], status_q[ARM_POS], byte_in[0]};
          state_d = S_IGNORE;
        end
        default: state_d = state_q;
      endcase
    end
    if (cs_fall)
    begin
      cs_active_d = 1'b1;
      mode3_d = sck_s2;
      bit_d = 3'h0;
      state_d = S_OPCODE;
    end
    else if (cs_rise)
    begin
      cs_active_d = 1'b0;
      state_d = S_IDLE;
    end
    so_oe_d = cs_active_d && hold_s2 && (state_d == S_RDATA || state_d == S_SRREAD);
    hw_d = status_d[STATUS_LOCK_POS] && !wp_s2;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_q <= S_IDLE;
      cs_active_q <= 1'b0;
      bit_q <= 3'h0;
      shift_q <= 7'h00;
      abyte_q <= 2'h0;
      is_read_q <= 1'b0;
      addr_q <= '0;
      tx_q <= 8'h00;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      status_q <= STATUS_RESET;
      mode3_q <= 1'b0;
      sleep_q <= 1'b0;
      rd_en_q <= 1'b0;
      rd_dv_q <= 1'b0;
      rd_addr_q <= '0;
      hw_q <= 1'b0;
      ovr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cs_active_q <= cs_active_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      abyte_q <= abyte_d;
      is_read_q <= is_read_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
      status_q <= status_d;
      mode3_q <= mode3_d;
      sleep_q <= sleep_d;
      rd_en_q <= rd_en_d;
      rd_dv_q <= rd_dv_d;
      rd_addr_q <= rd_addr_d;
      hw_q <= hw_d;
      ovr_q <= ovr_d;
    end
  end

  // Byte stream to the array; a full buffer drops the byte and flags it,
  // since the serial host cannot be stalled
  mram_write_fifo #(
    .WIDTH($bits(mem_write_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_rec),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr)
  );

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign mem_rd_en = rd_en_q;
  assign mem_rd_addr = rd_addr_q;
  assign status = status_q;
  assign mode3 = mode3_q;
  assign sleeping = sleep_q;
  assign hw_protect = hw_q;
  assign wr_overrun = ovr_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_mode_capture: assert property (cs_fall |=> mode3_q == $past(sck_s2))
    else $error("mode not taken from idle clock level");
  a_so_on_fall: assert property ($changed(so_q) |-> $past(fall_e))
    else $error("serial output changed outside a falling edge");
  a_arm_set: assert property (byte_done && state_q == S_OPCODE && !sleep_q && byte_in == OP_ARM
    |=> status_q[ARM_POS] ##1 status_q[ARM_POS])
    else $error("arm command did not set latch");
  a_disarm_clear: assert property (byte_done && state_q == S_OPCODE && !sleep_q && byte_in == OP_DISARM
    |=> !status_q[ARM_POS])
    else $error("disarm command did not clear latch");
  a_write_armed: assert property (push |-> status_q[ARM_POS])
    else $error("memory write while disarmed");
  a_write_guard: assert property (push |-> !guarded(status_q[GUARD_HI_POS:GUARD_LO_POS], push_rec.addr))
    else $error("write into guarded region");
  a_lock_holds: assert property (status_q[STATUS_LOCK_POS] && !wp_s2
    |=> status_q[7:2] == $past(status_q[7:2]))
    else $error("locked status changed with protect low");
  a_hw_protect: assert property (status_q[STATUS_LOCK_POS] && !wp_s2 && $past(!wp_s2) |-> hw_q)
    else $error("hardware protection not shown");
  a_so_float: assert property (so_oe_q |-> cs_active_q && $past(hold_s2))
    else $error("output driven while deselected or held");
  a_sleep_only: assert property (sleep_q && byte_done && state_q == S_OPCODE && byte_in != OP_WAKE
    |=> sleep_q && $stable(status_q))
    else $error("command accepted while asleep");
  a_rd_next: assert property (byte_done && state_q == S_RDATA |=> rd_en_q && rd_addr_q == $past(addr_q))
    else $error("sequential read address wrong");

  c_mem_read: cover property (rd_en_q && state_q == S_RDATA);
  c_mem_write: cover property (push);
  c_status_write: cover property (byte_done && state_q == S_SRWRITE && status_d != status_q);
  c_wake: cover property (sleep_q ##1 !sleep_q);
endmodule

// *** bench/spi_host_model.sv ***
/*
  Host side of the serial link: drives select, link clock, data and hold, reads the serial output.
  Assumes the bench calls one task at a time and that the system clock runs at 40 ns.
*/
`timescale 1ns/10ps

module spi_host_model (
  // System clock, only paces the link
  input wire logic clock,
  // Link pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  logic mode3_q;

  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    mode3_q = 1'b0;
  end

  // Half of a 320 ns link period, moved just after a clock edge
  task automatic half();
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic start(input logic m3);
    mode3_q = m3;
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
  endtask

  // Data is set while the link clock is low and read at its rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      si = tx[i];
      half();
      sck = 1'b1;
      // An undriven output reads inverted, so a missing enable shows up
      rx[i] = so_oe ? so : ~so;
      half();
    end
  endtask

  // Ends only on a byte boundary; the released data line is turned over
  task automatic stop();
    sck = mode3_q;
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
  endtask

  task automatic hold(input logic v);
    hold_n = v;
    half();
  endtask
endmodule

// *** bench/test_spi_mram_command_protect.sv ***
/*
  Self-checking bench for the serial memory front end, with an array model on the read and write ports.
  Assumes the host model paces the link at 320 ns per bit.
*/
`timescale 1ns/10ps

module test_spi_mram_command_protect
  import mram_spi_pkg::*;
();
  logic clock, resetn, cs_n, sck, si, hold_n, wp_n, so, so_oe, mem_rd_en;
  logic mem_wr_valid, mode3, sleeping, hw_protect, wr_overrun;
  logic mem_wr_ready = 1'b0;
  logic stall = 1'b0;
  logic [MEM_ADDR_BITS-1:0] mem_rd_addr;
  logic [7:0] mem_rd_data = 8'h00;
  logic [7:0] status, r;
  logic [7:0] seq = 8'h01;
  mem_write_t mem_wr;
  logic [7:0] mem [int];
  logic [7:0] shadow [int];
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  mram_spi_front i_mram_spi_front (.clock(clock), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr),
    .status(status), .mode3(mode3), .sleeping(sleeping), .hw_protect(hw_protect), .wr_overrun(wr_overrun));

  spi_host_model i_spi_host_model (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so(so), .so_oe(so_oe));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  function automatic logic [7:0] pattern(input int a);
    return a[7:0] ^ a[15:8];
  endfunction

  function automatic logic [7:0] exp_at(input int a);
    return shadow.exists(a) ? shadow[a] : pattern(a);
  endfunction

  function automatic logic [7:0] got_at(input int a);
    return mem.exists(a) ? mem[a] : pattern(a);
  endfunction

  always @(posedge clock)
  begin
    cycles++;
    // Array takes a record every other cycle so the buffer sees backpressure
    mem_wr_ready <= !stall && !mem_wr_ready;
    if (mem_rd_en === 1'b1)
      mem_rd_data <= got_at(int'(mem_rd_addr));
    if (mem_wr_valid === 1'b1 && mem_wr_ready)
      mem[int'(mem_wr.addr)] = mem_wr.data;
    if (cycles == 40000)
    begin
      num_errors++;
      $display("unexpected %0t: run too long", $time);
      summarize();
    end
  end

  // Armed and below the guarded upper region
  function automatic logic wr_ok(input logic [7:0] st, input int a);
    int lim;
    case (st[GUARD_HI_POS:GUARD_LO_POS])
      2'b00: lim = 32'h0008_0000;
      2'b01: lim = 32'h0006_0000;
      2'b10: lim = 32'h0004_0000;
      default: lim = 32'h0000_0000;
    endcase
    return st[ARM_POS] && a < lim;
  endfunction

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp, input string what);
    check_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic check_mem(input int a);
    check_byte(got_at(a), exp_at(a), "array byte");
  endtask

  task automatic op1(input logic [7:0] op);
    i_spi_host_model.start(1'b0);
    i_spi_host_model.xfer(op, r);
    i_spi_host_model.stop();
  endtask

  task automatic wr_status(input logic [7:0] v);
    i_spi_host_model.start(1'b0);
    i_spi_host_model.xfer(OP_STATUS_WRITE, r);
    i_spi_host_model.xfer(v, r);
    i_spi_host_model.stop();
  endtask

  task automatic rd_status(input logic [7:0] exp, input string what);
    logic [7:0] s;
    i_spi_host_model.start(1'b0);
    i_spi_host_model.xfer(OP_STATUS_READ, r);
    i_spi_host_model.xfer(8'hFF, s);
    i_spi_host_model.stop();
    check_byte(s, exp, what);
    check_byte(status, exp, what);
  endtask

  // Bytes whose index reaches keep are expected to be lost to a full buffer
  task automatic mem_write(input logic m3, input int a, input int n, input logic [7:0] st, input int keep);
    int b;
    i_spi_host_model.start(m3);
    i_spi_host_model.xfer(OP_MEM_WRITE, r);
    for (int i = 16; i >= 0; i -= 8)
      i_spi_host_model.xfer(a[i+:8], r);
    for (int i = 0; i < n; i++)
    begin
      b = (a + i) & 32'h0007_FFFF;
      seq++;
      i_spi_host_model.xfer(~pattern(b) ^ seq, r);
      if (wr_ok(st, b) && i < keep)
        shadow[b] = ~pattern(b) ^ seq;
    end
    i_spi_host_model.stop();
  endtask

  task automatic mem_read(input logic m3, input int a, input int n);
    logic [7:0] d;
    i_spi_host_model.start(m3);
    i_spi_host_model.xfer(OP_MEM_READ, r);
    for (int i = 16; i >= 0; i -= 8)
      i_spi_host_model.xfer(a[i+:8], r);
    for (int i = 0; i < n; i++)
    begin
      i_spi_host_model.xfer(8'hFF, d);
      check_byte(d, exp_at((a + i) & 32'h0007_FFFF), "read data");
    end
    i_spi_host_model.stop();
  endtask

  task automatic drain();
    for (int i = 0; i < 100 && mem_wr_valid !== 1'b0; i++)
      @(posedge clock);
    #1;
    check_flag(mem_wr_valid, 1'b0, "buffer empty");
  endtask

  task automatic set_wp(input logic v);
    @(posedge clock);
    #1;
    wp_n = v;
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic test_arm();
    rd_status(STATUS_RESET, "status after reset");
    check_flag(so_oe, 1'b0, "idle output enable");
    wr_status(8'h0C);
    rd_status(8'h00, "unarmed status write");
    mem_write(1'b0, 32'h0000_0100, 2, 8'h00, 2);
    drain();
    check_mem(32'h0000_0100);
    op1(OP_ARM);
    rd_status(8'h02, "armed");
    op1(OP_DISARM);
    rd_status(8'h00, "disarmed");
  endtask

  task automatic test_wrap();
    op1(OP_ARM);
    mem_write(1'b1, 32'h00F7_FFFE, 3, 8'h02, 3);
    check_flag(mode3, 1'b1, "mode 3 seen");
    drain();
    check_mem(32'h0007_FFFE);
    check_mem(32'h0000_0000);
    mem_read(1'b1, 32'h00FF_FFFF, 3);
    mem_read(1'b0, 32'h0001_2345, 2);
    check_flag(mode3, 1'b0, "mode 0 seen");
  endtask

  // Protect pin low all along: unlocked guards stay writable anyway
  task automatic test_guards();
    logic [7:0] st;
    int a;
    set_wp(1'b0);
    for (int g = 0; g < 4; g++)
    begin
      st = 8'(2 + 4 * g);
      wr_status(st);
      rd_status(st, "guard code");
      for (int k = 3; k < 8; k += 2)
      begin
        a = k * 32'h0001_0000 + 32'h0000_FFFF;
        mem_write(1'b0, a, 2, st, 2);
        drain();
        check_mem(a);
        check_mem((a + 1) & 32'h0007_FFFF);
      end
    end
    set_wp(1'b1);
  endtask

  task automatic test_lock();
    wr_status(8'h82);
    set_wp(1'b0);
    check_flag(hw_protect, 1'b1, "hardware protect on");
    wr_status(8'h0E);
    rd_status(8'h82, "locked status");
    set_wp(1'b1);
    check_flag(hw_protect, 1'b0, "hardware protect off");
    wr_status(8'h0E);
    rd_status(8'h0E, "unlocked status");
    wr_status(8'h02);
  endtask

  task automatic test_sleep();
    op1(OP_DISARM);
    op1(OP_SLEEP);
    check_flag(sleeping, 1'b1, "asleep");
    op1(OP_ARM);
    check_byte(status, 8'h00, "arm while asleep");
    op1(OP_WAKE);
    check_flag(sleeping, 1'b0, "awake");
    op1(OP_ARM);
    rd_status(8'h02, "arm after wake");
  endtask

  task automatic test_hold();
    logic [7:0] s;
    i_spi_host_model.start(1'b0);
    i_spi_host_model.xfer(OP_STATUS_READ, r);
    i_spi_host_model.hold(1'b0);
    repeat (2) @(posedge clock);
    #1;
    check_flag(so_oe, 1'b0, "output floats in hold");
    i_spi_host_model.xfer(8'h00, r);
    i_spi_host_model.hold(1'b1);
    i_spi_host_model.xfer(8'hFF, s);
    check_byte(s, 8'h02, "status after hold");
    i_spi_host_model.stop();
    check_flag(so_oe, 1'b0, "output floats deselected");
  endtask

  // Array stalls while 34 bytes arrive: 32 fit, the rest are lost
  task automatic test_fifo();
    stall = 1'b1;
    mem_write(1'b0, 32'h0000_1000, 34, 8'h02, 32);
    check_flag(mem_wr_valid, 1'b1, "buffer holding");
    check_flag(wr_overrun, 1'b1, "overrun seen");
    stall = 1'b0;
    drain();
    for (int i = 0; i < 34; i++)
      check_mem(32'h0000_1000 + i);
  endtask

  task automatic summarize();
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    resetn = 1'b0;
    wp_n = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    test_arm();
    test_wrap();
    test_guards();
    test_lock();
    test_sleep();
    test_hold();
    test_fifo();
    summarize();
  end
endmodule
